// ---- hdl/crhp_pkg.sv ----
// shared constants, types and helpers of the configuration register host port
// assumes a single 40 MHz clock and a 10-bit shared parallel bus
package crhp_pkg;

    // width of the shared parallel bus and of every configuration register
    localparam int CRHP_DATA_W = 10;
    // default number of configuration registers behind the port
    localparam int CRHP_REG_COUNT = 32;
    // value of every configuration register and bus output after reset
    localparam logic [CRHP_DATA_W-1:0] CRHP_RST_DATA = 10'h000;
    // value driven back for an address with no register behind it
    localparam logic [CRHP_DATA_W-1:0] CRHP_MISS_DATA = 10'h000;

    // address latching sequencer: which meaning the next write has
    typedef enum logic [0:0] {
        CRHP_SEQ_ADDR = 1'b0, // next write is taken as an address
        CRHP_SEQ_DATA = 1'b1  // next write is taken as data
    } crhp_seq_e;

    // host strobes and line qualifiers as sampled on one clock edge
    typedef struct packed {
        logic cs_n;     // chip select, low active
        logic rd_n;     // register read strobe, low active
        logic wr_n;     // register write strobe, low active
        logic sync;     // line sync, high during a line scan
        logic pix_rd_n; // pixel read strobe, low active
    } crhp_strobe_s;

    // a configuration register write as reported to the rest of the device
    typedef struct packed {
        logic we;                       // one-cycle write pulse
        logic [CRHP_DATA_W-1:0] addr;   // register address
        logic [CRHP_DATA_W-1:0] data;   // value written
    } crhp_cfgwr_s;

    // true when a latched address names an existing register
    function automatic logic crhp_hit(input logic [CRHP_DATA_W-1:0] a, input int unsigned n);
        return int'(a) < int'(n);
    endfunction

endpackage

// ---- hdl/crhp_regfile.sv ----
// storage of the configuration registers: one write port, one read port
// assumes the caller keeps addresses inside the depth; read data is registered
`timescale 1ns/10ps
module crhp_regfile
    import crhp_pkg::*;
#(
    parameter int DW = CRHP_DATA_W,
    parameter int DEPTH = CRHP_REG_COUNT,
    parameter int AW = $clog2(DEPTH)
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    // read port
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);

    // the register array itself
    logic [DW-1:0] mem_r [DEPTH];

    // refuse shapes the addressing cannot serve
    initial begin
        if (DEPTH < 2 || AW < $clog2(DEPTH)) begin
            $error("crhp_regfile: bad depth or address width");
        end
    end

    // writes, and a synchronous clear of every register at reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= DW'(CRHP_RST_DATA);
            end
        end else if (we_i && int'(waddr_i) < DEPTH) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    // registered read, shows a write one cycle later
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= DW'(CRHP_RST_DATA);
        end else if (int'(raddr_i) < DEPTH) begin
            rdata_o <= mem_r[raddr_i];
        end else begin
            rdata_o <= DW'(CRHP_MISS_DATA);
        end
    end

endmodule

// ---- hdl/crhp_top.sv ----
// parallel host port of the configuration register file
// assumes host strobes are synchronous to SYS_CLK_I; the pad combines
// BUS_O and BUS_OE_O with BUS_I outside this module
`timescale 1ns/10ps

// What this block does
// - register access only while chip select low
// - read with select, sync low drives register
// - first cycle of every selected read resets address sequencer
// - read without select drives bus, undefined data
// - write with select captures bus value
// - first write of sequence latches address
// - second write stores data at latched address
// - writes accepted whatever line sync level
// - sync high, pixel read low outputs pixel
module crhp_top
    import crhp_pkg::*;
#(
    parameter int REG_COUNT = CRHP_REG_COUNT
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // host strobes
    input wire logic CS_N_I,
    input wire logic RD_N_I,
    input wire logic WR_N_I,
    // line qualifiers
    input wire logic LINE_SYNC_I,
    input wire logic PIX_RD_N_I,
    input wire logic [CRHP_DATA_W-1:0] PIX_DATA_I,
    // shared parallel bus, split into its three signals
    input wire logic [CRHP_DATA_W-1:0] SHARED_PARALLEL_BUS_I,
    output logic [CRHP_DATA_W-1:0] SHARED_PARALLEL_BUS_O,
    output logic SHARED_PARALLEL_BUS_OE_O,
    // write report to the rest of the device
    output logic CFG_WE_O,
    output logic [CRHP_DATA_W-1:0] CFG_ADDR_O,
    output logic [CRHP_DATA_W-1:0] CFG_DATA_O,
    // sequencer state for observation
    output logic SEQ_DATA_O
);

    localparam int AW = $clog2(REG_COUNT);

    // refuse a register count the 10-bit address cannot reach
    initial begin
        if (REG_COUNT < 2 || REG_COUNT > (1 << CRHP_DATA_W)) begin
            $error("crhp_top: REG_COUNT out of range");
        end
    end

    // strobes gathered into one carrier
    crhp_strobe_s strb;
    assign strb = '{cs_n: CS_N_I, rd_n: RD_N_I, wr_n: WR_N_I,
                    sync: LINE_SYNC_I, pix_rd_n: PIX_RD_N_I};

    // state of the port
    crhp_seq_e seq_r;                       // address latching sequencer
    crhp_seq_e seq_nxt;                     // its next value
    logic [CRHP_DATA_W-1:0] addr_r;         // latched register address
    logic [CRHP_DATA_W-1:0] addr_nxt;       // its next value
    logic wr_act_d_r;                       // write strobe seen last cycle
    logic rd_act_d_r;                       // read strobe seen last cycle
    crhp_cfgwr_s cfg_r;                     // registered write report
    crhp_cfgwr_s cfg_nxt;                   // its next value
    logic [CRHP_DATA_W-1:0] bus_nxt;        // next bus value
    logic oe_nxt;                           // next bus enable
    logic [CRHP_DATA_W-1:0] bus_r;          // bus value register
    logic oe_r;                             // bus enable register
    logic [CRHP_DATA_W-1:0] rd_data;        // registered regfile read data

    // strobe decode
    wire wr_act = !strb.wr_n && !strb.cs_n;
    wire rd_act = !strb.rd_n && !strb.cs_n;
    wire wr_start = wr_act && !wr_act_d_r;                   // one pulse per write
    wire rd_start = rd_act && !rd_act_d_r;                   // one pulse per read
    wire pix_sel = strb.sync && !strb.pix_rd_n;
    wire reg_sel = rd_act && !strb.sync;
    wire stray_sel = !strb.rd_n && strb.cs_n;
    wire addr_phase = wr_start && (seq_r == CRHP_SEQ_ADDR);
    wire data_phase = wr_start && (seq_r == CRHP_SEQ_DATA);
    wire addr_hit = crhp_hit(addr_r, REG_COUNT);             // register exists
    wire data_we = data_phase && addr_hit;                   // store enable
    // an address past the file reads as the miss value, not an aliased register
    wire [CRHP_DATA_W-1:0] rd_word = addr_hit ? rd_data : CRHP_MISS_DATA;

    // sequencer: a read restarts it, writes alternate address and data
    always_comb begin
        seq_nxt = seq_r;
        if (rd_start) begin
            seq_nxt = CRHP_SEQ_ADDR;
        end else if (addr_phase) begin
            seq_nxt = CRHP_SEQ_DATA;
        end else if (data_phase) begin
            seq_nxt = CRHP_SEQ_ADDR;
        end
    end

    // address latch takes the bus on the first write
    assign addr_nxt = addr_phase ? SHARED_PARALLEL_BUS_I : addr_r;

    // write report follows the data write by one cycle
    assign cfg_nxt = '{we: data_phase,
                       addr: data_phase ? addr_r : cfg_r.addr,
                       data: data_phase ? SHARED_PARALLEL_BUS_I : cfg_r.data};

    // bus source: pixel data first, then register, then a stray read
    always_comb begin
        bus_nxt = bus_r;
        oe_nxt = 1'b0;
        if (pix_sel) begin
            bus_nxt = PIX_DATA_I;
            oe_nxt = 1'b1;
        end else if (reg_sel) begin
            bus_nxt = rd_word;
            oe_nxt = 1'b1;
        end else if (stray_sel) begin
            bus_nxt = PIX_DATA_I ^ rd_data;
            oe_nxt = 1'b1;
        end
    end

    // sequencer and address registers
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            seq_r <= CRHP_SEQ_ADDR;
            addr_r <= CRHP_RST_DATA;
        end else begin
            seq_r <= seq_nxt;
            addr_r <= addr_nxt;
        end
    end

    // strobe history for edge detection
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            wr_act_d_r <= 1'b0;
            rd_act_d_r <= 1'b0;
        end else begin
            wr_act_d_r <= wr_act;
            rd_act_d_r <= rd_act;
        end
    end

    // output registers
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            cfg_r <= '{we: 1'b0, addr: CRHP_RST_DATA, data: CRHP_RST_DATA};
            bus_r <= CRHP_RST_DATA;
            oe_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            bus_r <= bus_nxt;
            oe_r <= oe_nxt;
        end
    end

    // register storage, read at the latched address
    crhp_regfile #(
        .DW(CRHP_DATA_W),
        .DEPTH(REG_COUNT),
        .AW(AW)
    ) u_regfile (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .we_i(data_we),
        .waddr_i(addr_r[AW-1:0]),
        .wdata_i(SHARED_PARALLEL_BUS_I),
        .raddr_i(addr_r[AW-1:0]),
        .rdata_o(rd_data)
    );

    // ports from flip-flops
    assign SHARED_PARALLEL_BUS_O = bus_r;
    assign SHARED_PARALLEL_BUS_OE_O = oe_r;
    assign CFG_WE_O = cfg_r.we;
    assign CFG_ADDR_O = cfg_r.addr;
    assign CFG_DATA_O = cfg_r.data;
    assign SEQ_DATA_O = (seq_r == CRHP_SEQ_DATA);

    // a write strobe without chip select leaves the sequencer alone
    a_cs_gates_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (!WR_N_I && CS_N_I && RD_N_I) |=> $stable(seq_r) && !CFG_WE_O)
        else $error("write without chip select changed state");

    // a qualified register read drives the registered read data
    a_read_drives_reg: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (!CS_N_I && !RD_N_I && !LINE_SYNC_I) |=> SHARED_PARALLEL_BUS_OE_O
        && SHARED_PARALLEL_BUS_O == $past(rd_word))
        else $error("register read not driven on bus");

    // the first cycle of a selected read sends the sequencer back to address
    a_read_resets_seq: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (!CS_N_I && !RD_N_I && !rd_act_d_r) |=> !SEQ_DATA_O)
        else $error("read did not reset sequencer");

    // a read strobe without select still turns the bus on
    a_stray_read_oe: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (!RD_N_I && CS_N_I) |=> SHARED_PARALLEL_BUS_OE_O)
        else $error("stray read left bus released");

    // a data write reports exactly the bus value seen
    a_write_capture: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (data_phase && RD_N_I) |=> CFG_DATA_O == $past(SHARED_PARALLEL_BUS_I))
        else $error("write data not captured");

    // the first write becomes the address and stores nothing
    a_addr_latch: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (!CS_N_I && !WR_N_I && !wr_act_d_r && !SEQ_DATA_O && RD_N_I)
        |=> addr_r == $past(SHARED_PARALLEL_BUS_I) && SEQ_DATA_O && !CFG_WE_O)
        else $error("address write mishandled");

    // the second write, two idle cycles later, goes to the address the first carried
    a_data_store: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (addr_phase && RD_N_I) ##1 (!wr_start && RD_N_I) [*2] ##1 (data_phase && RD_N_I)
        |=> CFG_WE_O && CFG_ADDR_O == $past(SHARED_PARALLEL_BUS_I, 4) && !SEQ_DATA_O)
        else $error("data write not stored at latched address");

    // writes pass during a line scan too
    a_write_any_sync: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (data_phase && LINE_SYNC_I) |=> CFG_WE_O)
        else $error("write blocked by line sync");

    // pixel read during a line scan shows pixel data, not registers
    a_pixel_out: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (LINE_SYNC_I && !PIX_RD_N_I) |=> SHARED_PARALLEL_BUS_OE_O
        && SHARED_PARALLEL_BUS_O == $past(PIX_DATA_I))
        else $error("pixel data not driven");

    // the bus is released when nothing selects it
    a_bus_idle: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (RD_N_I && !(LINE_SYNC_I && !PIX_RD_N_I)) |=> !SHARED_PARALLEL_BUS_OE_O)
        else $error("bus driven while unselected");

endmodule

// ---- bench/crhp_host_model.sv ----
// host side of the shared parallel bus: resolves the pin level seen by the port
// assumes the bench drives the host strobes; the bus has no pull resistor
`timescale 1ns/10ps
module crhp_host_model
    import crhp_pkg::*;
(
    // clock
    input wire logic clk_i,
    // host drive
    input wire logic host_oe_i,
    input wire logic [CRHP_DATA_W-1:0] host_d_i,
    // device drive
    input wire logic dev_oe_i,
    input wire logic [CRHP_DATA_W-1:0] dev_d_i,
    // resolved pin level
    output logic [CRHP_DATA_W-1:0] bus_o
);
    // last level on the pins
    logic [CRHP_DATA_W-1:0] last_r = 10'h000;
    // a released bus toggles each cycle, so stale data can never match
    assign bus_o = dev_oe_i ? dev_d_i : (host_oe_i ? host_d_i : ~last_r);
    // remember the level for the released case
    always @(posedge clk_i) begin
        last_r <= bus_o;
    end
endmodule

// ---- bench/crhp_top_tb.sv ----
// self-checking bench of the configuration register host port
// assumes default REG_COUNT; strobes change at rising edges, outputs read at falling
`timescale 1ns/10ps
module crhp_top_tb
    import crhp_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    logic sync = 1'b0, pix_rd_n = 1'b1, host_oe = 1'b0, oe, cfg_we, seq;
    logic [CRHP_DATA_W-1:0] pix_d = 10'h000, host_d = 10'h000, bus_i, dout, cfg_a, cfg_d;
    logic [CRHP_DATA_W-1:0] shadow [CRHP_REG_COUNT]; // expected register contents
    logic [31:0] seed = 32'h4866; // random source state
    int num_errors = 0, samples_checked = 0;

    crhp_host_model host (.clk_i(clk), .host_oe_i(host_oe), .host_d_i(host_d),
        .dev_oe_i(oe), .dev_d_i(dout), .bus_o(bus_i));
    crhp_top dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CS_N_I(cs_n), .RD_N_I(rd_n),
        .WR_N_I(wr_n), .LINE_SYNC_I(sync), .PIX_RD_N_I(pix_rd_n), .PIX_DATA_I(pix_d),
        .SHARED_PARALLEL_BUS_I(bus_i), .SHARED_PARALLEL_BUS_O(dout),
        .SHARED_PARALLEL_BUS_OE_O(oe), .CFG_WE_O(cfg_we), .CFG_ADDR_O(cfg_a),
        .CFG_DATA_O(cfg_d), .SEQ_DATA_O(seq));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // next random word
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected read value of an address
    function automatic logic [CRHP_DATA_W-1:0] expect_rd(input logic [CRHP_DATA_W-1:0] a);
        return (a < CRHP_REG_COUNT) ? shadow[a[4:0]] : CRHP_MISS_DATA;
    endfunction

    // compare a bus-wide value
    task automatic chk_val(input logic [CRHP_DATA_W-1:0] got, input logic [CRHP_DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask

    // compare a flag
    task automatic chk_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic complete_run();
        $display("checked %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one selected write strobe; host drives the bus only while selected
    task automatic wr_one(input logic [CRHP_DATA_W-1:0] v);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        host_oe <= 1'b1;
        host_d <= v;
        @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        host_oe <= 1'b0;
    endtask

    // address then data, checking the write report
    task automatic wr_pair(input logic [CRHP_DATA_W-1:0] a, input logic [CRHP_DATA_W-1:0] d);
        int k;
        wr_one(a);
        repeat (2) @(negedge clk);
        chk_flag(seq, 1'b1);
        wr_one(d);
        for (k = 0; k < 4 && cfg_we !== 1'b1; k++) @(negedge clk);
        if (cfg_we !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: no write pulse", $time);
            complete_run();
        end
        chk_val(cfg_a, a);
        chk_val(cfg_d, d);
        if (a < CRHP_REG_COUNT) shadow[a[4:0]] = d;
        @(negedge clk);
        chk_flag(cfg_we, 1'b0);
        chk_flag(seq, 1'b0);
    endtask

    // address write, then a selected read; sync and pixel read stay as set
    task automatic rd_chk(input logic [CRHP_DATA_W-1:0] a, input logic eoe,
        input logic [CRHP_DATA_W-1:0] exp);
        wr_one(a);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk_flag(oe, eoe);
        if (eoe) chk_val(dout, exp);
        if (!sync) chk_flag(seq, 1'b0);
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask

    // main sequence
    initial begin
        int i;
        for (i = 0; i < CRHP_REG_COUNT; i++) shadow[i] = CRHP_RST_DATA;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_flag(oe, 1'b0);
        chk_flag(seq, 1'b0);
        $display("test reset done");
        // random pairs, sync random; two addresses past the file
        for (i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            sync <= seed[20];
            wr_pair(i == 33 ? 10'h3ff : (i < 33 ? 10'(i) : 10'(seed[4:0])), seed[13:4]);
        end
        sync <= 1'b0;
        $display("test writes done");
        // read back every register and the missing ones
        for (i = 0; i < 34; i++) rd_chk(10'(i), 1'b1, expect_rd(10'(i)));
        rd_chk(10'h3ff, 1'b1, CRHP_MISS_DATA);
        wr_pair(10'h005, 10'h2a5);
        rd_chk(10'h005, 1'b1, 10'h2a5);
        $display("test reads done");
        // strobe without select is ignored
        @(posedge clk);
        wr_n <= 1'b0;
        @(posedge clk);
        wr_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk_flag(seq, 1'b0);
        // register read during a line scan gives nothing
        sync <= 1'b1;
        rd_chk(10'h005, 1'b0, 10'h000);
        // pixel path during a line scan
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            @(posedge clk);
            pix_rd_n <= 1'b0;
            pix_d <= seed[9:0];
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk_flag(oe, 1'b1);
            chk_val(dout, seed[9:0]);
        end
        @(posedge clk);
        pix_rd_n <= 1'b1;
        sync <= 1'b0;
        $display("test line scan done");
        // read without select drives the bus
        @(posedge clk);
        rd_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_flag(oe, 1'b1);
        @(posedge clk);
        rd_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk_flag(oe, 1'b0);
        $display("test stray read done");
        complete_run();
    end
endmodule
